/* src/otpud_pkg.sv */
// constants, field layouts and carrier types for the otp descriptor override block
// assumes a byte-wide otp array seen as one byte per wishbone word
package otpud_pkg;

    // ==========================================================
    // otp entry indices (byte address = index * 4)
    localparam int IDX_W = 9;
    localparam int OTP_DEPTH = 512;
    localparam logic [8:0] IDX_VALID = 9'h004;
    localparam logic [8:0] IDX_ATTR = 9'h010;
    localparam logic [8:0] IDX_MAXPWR = 9'h011;
    localparam logic [8:0] IDX_MAKER = 9'h012;
    localparam logic [8:0] IDX_ITEM = 9'h022;
    localparam logic [8:0] IDX_UNIT = 9'h032;
    localparam logic [8:0] IDX_PATCH_FIRST = 9'h042;
    localparam logic [8:0] IDX_PATCH_LAST = 9'h1FF;
    localparam logic [8:0] PATCH_STEP = 9'h002;

    // ==========================================================
    // wishbone address layout
    localparam int WB_ADR_W = 12;
    localparam int WB_IDX_LSB = 2;
    localparam int WB_OOR_BIT = 11;

    // ==========================================================
    // fields
    localparam int VALID_USB_BIT = 0;
    localparam int VALID_STR_BIT = 1;
    localparam int ATTR_WAKE_BIT = 5;
    localparam int ATTR_SELF_BIT = 6;
    localparam logic [7:0] ATTR_USED_MASK = 8'h60;
    localparam logic [7:0] ATTR_FIXED_ONE = 8'h80;
    localparam int MA_PER_POWER_COUNT = 2;

    // ==========================================================
    // strings
    localparam int STR_BYTES = 16;
    localparam int STR_COUNT = 3;
    localparam logic [1:0] SEL_MAKER = 2'h0;
    localparam logic [1:0] SEL_ITEM = 2'h1;
    localparam logic [1:0] SEL_UNIT = 2'h2;
    localparam logic [4:0] STR_LEN_FULL = 5'h10;

    // ==========================================================
    // types
    typedef struct packed {
        logic [7:0] attributes;
        logic [7:0] max_power;
    } otpud_desc_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] value;
    } otpud_patch_t;

    typedef enum logic [0:0] {
        ST_WALK,
        ST_DONE
    } otpud_state_t;

endpackage

/* src/otpud_str_len.sv */
// length finder for one null-terminated 16-byte string
// assumes the text is packed with byte 0 in the low bits
`timescale 1ns/1ps
`default_nettype none
module otpud_str_len
    import otpud_pkg::*;
(
    input wire logic [8*STR_BYTES-1:0] text_i,
    output logic [4:0] len_o
);

    // ==========================================================
    // first zero byte wins; no zero means a full string
    always_comb begin
        len_o = STR_LEN_FULL;
        for (int i = STR_BYTES - 1; i >= 0; i--) begin
            if (text_i[8*i +: 8] == 8'h00) begin
                len_o = 5'(i);
            end
        end
    end

endmodule
`default_nettype wire

/* src/otpud_top.sv */
// otp descriptor override block: otp entry array on classic wishbone,
// descriptor override outputs, string byte port and power-up patch walk
// assumes one clock, synchronous reset and a single-cycle wishbone master
// Notes on behaviour
// - with the usb override flag set, attribute bit five is reported as remote wakeup.
// - with the usb override flag set, attribute bit six is reported as self powered.
// - with the usb override flag set, bus power needed by a self-powered device comes from the power budget entry only.
// - with the usb override flag set, the power budget byte goes to max power in 2 mA units.
// - the manufacturer string comes from sixteen entries and ends at the first zero byte.
// - the product string comes from sixteen entries of null-terminated text.
// - the serial number string comes from sixteen entries of null-terminated text.
// - reset clears the patch pairs, so the walk ends at its first entry after reset and defaults ready comes with no patch pulse.
// - bit zero of the valid entry selects otp values for the configuration attributes and max power fields.
`timescale 1ns/1ps
`default_nettype none
module otpud_top
    import otpud_pkg::*;
#(
    parameter logic [7:0] BUILTIN_ATTR = 8'h80,
    parameter logic [7:0] BUILTIN_MAX_POWER = 8'h32
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output otpud_desc_t desc_o,
    output logic usb_override_o,
    output logic strings_override_o,
    input wire logic [1:0] str_sel_i,
    input wire logic [3:0] str_idx_i,
    output logic [7:0] str_byte_o,
    output logic [4:0] str_len_o,
    output otpud_patch_t patch_o,
    output logic patch_valid_o,
    output logic defaults_ready_o
);

    // ==========================================================
    // helpers
    function automatic logic is_mapped(input logic [WB_ADR_W-1:0] adr);
        return !adr[WB_OOR_BIT];
    endfunction

    function automatic logic [8:0] str_base(input logic [1:0] sel);
        case (sel)
            SEL_MAKER: str_base = IDX_MAKER;
            SEL_ITEM: str_base = IDX_ITEM;
            default: str_base = IDX_UNIT;
        endcase
    endfunction

    // ==========================================================
    // otp entry array; a write can only set bits, as in fuse memory
    logic [7:0] mem_q [OTP_DEPTH];
    logic bus_req;
    logic [8:0] bus_idx;
    logic bus_wr;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign bus_idx = wb_adr_i[WB_IDX_LSB +: IDX_W];
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && is_mapped(wb_adr_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < OTP_DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (bus_wr) begin
            mem_q[bus_idx] <= mem_q[bus_idx] | wb_dat_i[7:0];
        end
    end

    // ==========================================================
    // wishbone slave: answer one cycle after the request
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic [31:0] rdat_q, rdat_d;

    always_comb begin
        ack_d = bus_req && is_mapped(wb_adr_i);
        err_d = bus_req && !is_mapped(wb_adr_i);
        rdat_d = rdat_q;
        if (ack_d) begin
            rdat_d = {24'h000000, mem_q[bus_idx]};
        end else if (err_d) begin
            rdat_d = 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    // ==========================================================
    // descriptor override
    logic usb_ovr;
    logic [7:0] attr_entry;
    otpud_desc_t desc_q, desc_d;
    logic usb_q, usb_d;
    logic str_ovr_q, str_ovr_d;

    assign usb_ovr = mem_q[IDX_VALID][VALID_USB_BIT];
    assign attr_entry = mem_q[IDX_ATTR];

    always_comb begin
        usb_d = usb_ovr;
        str_ovr_d = mem_q[IDX_VALID][VALID_STR_BIT];
        if (usb_ovr) begin
            // reserved entry bits are masked so a stray fuse cannot leak out
            desc_d.attributes = ATTR_FIXED_ONE | (attr_entry & ATTR_USED_MASK);
            desc_d.max_power = mem_q[IDX_MAXPWR];
        end else begin
            desc_d.attributes = BUILTIN_ATTR;
            desc_d.max_power = BUILTIN_MAX_POWER;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            desc_q <= '{attributes: BUILTIN_ATTR, max_power: BUILTIN_MAX_POWER};
            usb_q <= 1'b0;
            str_ovr_q <= 1'b0;
        end else begin
            desc_q <= desc_d;
            usb_q <= usb_d;
            str_ovr_q <= str_ovr_d;
        end
    end

    assign desc_o = desc_q;
    assign usb_override_o = usb_q;
    assign strings_override_o = str_ovr_q;

    // ==========================================================
    // string lengths, one finder per string
    logic [4:0] str_len [STR_COUNT];

    for (genvar g = 0; g < STR_COUNT; g++) begin : g_str
        logic [8*STR_BYTES-1:0] text;
        for (genvar k = 0; k < STR_BYTES; k++) begin : g_byte
            assign text[8*k +: 8] = mem_q[9'(int'(IDX_MAKER) + g * STR_BYTES + k)];
        end
        otpud_str_len otpud_str_len_inst (
            .text_i(text),
            .len_o(str_len[g])
        );
    end

    // ==========================================================
    // string byte port: bytes at or past the terminator read as zero
    logic [7:0] sbyte_q, sbyte_d;
    logic [4:0] slen_q, slen_d;
    logic [4:0] sel_len;

    always_comb begin
        sel_len = 5'h00;
        if (str_sel_i == SEL_MAKER || str_sel_i == SEL_ITEM || str_sel_i == SEL_UNIT) begin
            sel_len = str_len[str_sel_i];
        end
        slen_d = sel_len;
        sbyte_d = 8'h00;
        if ({1'b0, str_idx_i} < sel_len) begin
            sbyte_d = mem_q[str_base(str_sel_i) + {5'h00, str_idx_i}];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sbyte_q <= 8'h00;
            slen_q <= 5'h00;
        end else begin
            sbyte_q <= sbyte_d;
            slen_q <= slen_d;
        end
    end

    assign str_byte_o = sbyte_q;
    assign str_len_o = slen_q;

    // ==========================================================
    // power-up patch walk over address/value pairs
    otpud_state_t st_q, st_d;
    logic [8:0] ptr_q, ptr_d;
    otpud_patch_t patch_q, patch_d;
    logic pvalid_q, pvalid_d;

    always_comb begin
        st_d = st_q;
        ptr_d = ptr_q;
        patch_d = patch_q;
        pvalid_d = 1'b0;
        case (st_q)
            ST_WALK: begin
                if (ptr_q >= IDX_PATCH_LAST || mem_q[ptr_q] == 8'h00) begin
                    st_d = ST_DONE;
                end else begin
                    patch_d.addr = mem_q[ptr_q];
                    patch_d.value = mem_q[ptr_q + 9'h001];
                    pvalid_d = 1'b1;
                    ptr_d = ptr_q + PATCH_STEP;
                end
            end
            ST_DONE: begin
                st_d = ST_DONE;
            end
            default: begin
                st_d = ST_DONE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_WALK;
            ptr_q <= IDX_PATCH_FIRST;
            patch_q <= '{addr: 8'h00, value: 8'h00};
            pvalid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ptr_q <= ptr_d;
            patch_q <= patch_d;
            pvalid_q <= pvalid_d;
        end
    end

    assign patch_o = patch_q;
    assign patch_valid_o = pvalid_q;
    // ready only after the last patch pulse has left
    assign defaults_ready_o = (st_q == ST_DONE) && !pvalid_q;

    // ==========================================================
    // checks
    a_wake_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(usb_ovr) && !$past(rst_i) |->
        desc_o.attributes[ATTR_WAKE_BIT] == $past(attr_entry[ATTR_WAKE_BIT]))
        else $error("remote wakeup bit does not follow the attribute entry");

    a_self_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(usb_ovr) && !$past(rst_i) |->
        desc_o.attributes[ATTR_SELF_BIT] == $past(attr_entry[ATTR_SELF_BIT]))
        else $error("self powered bit does not follow the attribute entry");

    a_power_budget: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(usb_ovr) && !$past(rst_i) |-> desc_o.max_power == $past(mem_q[IDX_MAXPWR]))
        else $error("max power does not follow the power budget entry");

    a_power_indep: assert property (@(posedge clk_i) disable iff (rst_i)
        usb_override_o && $past(usb_override_o) && $stable(desc_o.attributes) &&
        $changed(desc_o.max_power) |->
        $past(mem_q[IDX_MAXPWR], 2) != $past(mem_q[IDX_MAXPWR], 1) || $past(rst_i))
        else $error("max power changed without a power budget change");

    a_builtin_vals: assert property (@(posedge clk_i) disable iff (rst_i)
        !usb_override_o |->
        desc_o.attributes == BUILTIN_ATTR && desc_o.max_power == BUILTIN_MAX_POWER)
        else $error("built-in descriptor values not reported without override");

    a_flag_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> usb_override_o == $past(mem_q[IDX_VALID][VALID_USB_BIT]))
        else $error("usb override flag does not follow the valid entry");

    a_str_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && {1'b0, $past(str_idx_i)} >= str_len_o |-> str_byte_o == 8'h00)
        else $error("string byte past the terminator is not zero");

    a_item_text: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && $past(str_sel_i) == SEL_ITEM && {1'b0, $past(str_idx_i)} < str_len_o
        |-> str_byte_o == $past(mem_q[IDX_ITEM + {5'h00, str_idx_i}]) && str_byte_o != 8'h00)
        else $error("product string byte is wrong");

    a_unit_text: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && $past(str_sel_i) == SEL_UNIT && {1'b0, $past(str_idx_i)} < str_len_o
        |-> str_byte_o == $past(mem_q[IDX_UNIT + {5'h00, str_idx_i}]) && str_byte_o != 8'h00)
        else $error("serial number string byte is wrong");

    a_patch_first: assert property (@(posedge clk_i) disable iff (rst_i)
        patch_valid_o |-> !defaults_ready_o ##1 (defaults_ready_o || patch_valid_o ||
        st_q == ST_DONE))
        else $error("patch pulse overlaps defaults ready");

    a_ready_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        defaults_ready_o |=> defaults_ready_o && !patch_valid_o)
        else $error("defaults ready dropped or a patch followed it");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack longer than one cycle");

endmodule
`default_nettype wire

/* testbench/otpud_host_model.sv */
// host-side model: reads string descriptor bytes through the string port
// assumes the block answers one clock after it samples select and index
`timescale 1ns/1ps
`default_nettype none
module otpud_host_model
    import otpud_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] str_byte_i,
    input wire logic [4:0] str_len_i,
    output logic [1:0] str_sel_o,
    output logic [3:0] str_idx_o
);
    initial begin
        str_sel_o = 2'h3;
        str_idx_o = 4'h0;
    end

    // ==========================================================
    // one byte fetch; select goes back to none between fetches
    task automatic fetch(input logic [1:0] sel, input logic [3:0] idx,
                         output logic [7:0] b, output logic [4:0] len);
        @(posedge clk_i);
        str_sel_o <= sel;
        str_idx_o <= idx;
        @(posedge clk_i);
        @(posedge clk_i);
        b = str_byte_i;
        len = str_len_i;
        str_sel_o <= 2'h3;
        str_idx_o <= ~idx;
    endtask
endmodule
`default_nettype wire

/* testbench/otpud_tb_top.sv */
// self-checking bench: wishbone entry tasks plus a descriptor-reading host
// assumes every taken request is answered by ack or err
`timescale 1ns/1ps
`default_nettype none
module otpud_tb_top
    import otpud_pkg::*;
;
    localparam logic [7:0] DEF_ATTR = 8'h80;
    localparam logic [7:0] DEF_PWR = 8'h32;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [WB_ADR_W-1:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    otpud_desc_t desc_o;
    logic usb_override_o;
    logic strings_override_o;
    logic [1:0] str_sel;
    logic [3:0] str_idx;
    logic [7:0] str_byte;
    logic [4:0] str_len;
    otpud_patch_t patch_o;
    logic patch_valid_o;
    logic defaults_ready_o;
    int bad_count = 0;
    int n_compared = 0;
    int pulses = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] sb;
    logic [4:0] sl;

    always #50 clk_i = ~clk_i;

    otpud_top #(.BUILTIN_ATTR(DEF_ATTR), .BUILTIN_MAX_POWER(DEF_PWR)) otpud_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .desc_o(desc_o),
        .usb_override_o(usb_override_o), .strings_override_o(strings_override_o),
        .str_sel_i(str_sel), .str_idx_i(str_idx), .str_byte_o(str_byte),
        .str_len_o(str_len), .patch_o(patch_o), .patch_valid_o(patch_valid_o),
        .defaults_ready_o(defaults_ready_o));

    otpud_host_model otpud_host_model_inst (
        .clk_i(clk_i), .str_byte_i(str_byte), .str_len_i(str_len),
        .str_sel_o(str_sel), .str_idx_o(str_idx));

    always @(posedge clk_i) begin
        if (patch_valid_o === 1'b1) begin
            pulses++;
        end
    end

    // ==========================================================
    // common tasks
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [7:0] dat,
                           output logic [31:0] rdata, output logic err);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, dat};
        // wait for ack or err; the watchdog ends a wait that gets neither
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        chk({31'h0, wb_ack_o & wb_err_o}, 32'h0);
        rdata = wb_dat_o;
        err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] idx, input logic [7:0] dat);
        wb_xfer(1'b1, {1'b0, idx, 2'b00}, dat, rd, er);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic rd_chk(input logic [8:0] idx, input logic [7:0] exp);
        wb_xfer(1'b0, {1'b0, idx, 2'b00}, 8'h00, rd, er);
        chk(rd, {24'h0, exp});
    endtask

    initial begin
        #(100ns * 3000);
        chk(32'h0, 32'h1);
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk({31'h0, defaults_ready_o}, 32'h1);
        chk({16'h0, desc_o}, {16'h0, DEF_ATTR, DEF_PWR});
        wr(IDX_ATTR, 8'h20);
        wr(IDX_MAXPWR, 8'hFA);
        @(negedge clk_i);
        chk({16'h0, desc_o}, {16'h0, DEF_ATTR, DEF_PWR});
        wr(IDX_VALID, 8'h01);
        @(negedge clk_i);
        chk({31'h0, usb_override_o}, 32'h1);
        chk({16'h0, desc_o}, {16'h0, ATTR_FIXED_ONE | 8'h20, 8'hFA});
        wr(IDX_ATTR, 8'h40);
        @(negedge clk_i);
        chk({16'h0, desc_o}, {16'h0, ATTR_FIXED_ONE | 8'h60, 8'hFA});
        rd_chk(IDX_ATTR, 8'h60);
        rd_chk(IDX_MAXPWR, 8'hFA);
        wb_xfer(1'b1, 12'h840, 8'h1F, rd, er);
        chk({31'h0, er}, 32'h1);
        wb_xfer(1'b0, 12'h800, 8'h00, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        rd_chk(IDX_ATTR, 8'h60);
        // maker "AB", product 16 letters with no terminator, serial left blank
        wr(IDX_MAKER, 8'h41);
        wr(IDX_MAKER + 9'h001, 8'h42);
        for (int i = 0; i < STR_BYTES; i++) begin
            wr(IDX_ITEM + 9'(i), 8'h61 + 8'(i));
        end
        wr(IDX_VALID, 8'h02);
        @(negedge clk_i);
        chk({31'h0, strings_override_o}, 32'h1);
        otpud_host_model_inst.fetch(SEL_MAKER, 4'h1, sb, sl);
        chk({24'h0, sb}, 32'h42);
        chk({27'h0, sl}, 32'h2);
        otpud_host_model_inst.fetch(SEL_MAKER, 4'h2, sb, sl);
        chk({24'h0, sb}, 32'h0);
        otpud_host_model_inst.fetch(SEL_ITEM, 4'hF, sb, sl);
        chk({24'h0, sb}, 32'h70);
        chk({27'h0, sl}, {27'h0, STR_LEN_FULL});
        otpud_host_model_inst.fetch(SEL_UNIT, 4'h0, sb, sl);
        chk({19'h0, sl, sb}, 32'h0);
        wr(IDX_UNIT, 8'h5A);
        otpud_host_model_inst.fetch(SEL_UNIT, 4'h0, sb, sl);
        chk({19'h0, sl, sb}, {19'h0, 5'h01, 8'h5A});
        otpud_host_model_inst.fetch(2'h3, 4'h0, sb, sl);
        chk({19'h0, sl, sb}, 32'h0);
        chk(pulses, 32'h0);
        chk({31'h0, defaults_ready_o}, 32'h1);
        chk({16'h0, patch_o}, 32'h0);
        // reset in mid-run clears the entries and restarts the walk
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk({31'h0, usb_override_o}, 32'h0);
        chk({16'h0, desc_o}, {16'h0, DEF_ATTR, DEF_PWR});
        chk({31'h0, defaults_ready_o}, 32'h1);
        rd_chk(IDX_ATTR, 8'h00);
        chk(pulses, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
